/* pkg/osm_pkg.sv */
// Constants, types and map for the oscillator mode select block
// What this block does
// - Ten oscillator modes chosen by a four-bit config field captured at configuration time.
// - Crystal modes reserve both oscillator pins for the crystal, never as I/O.
// - External clock modes take clock on the input pin with no start-up delay.
// - External clock with output drives the output pin at device clock divided by four.
// - External clock with I/O turns the output pin into port bit 6.
// - RC with output drives the output pin at oscillator clock divided by four.
// - RC with I/O turns the output pin into port bit 6.
// - Multiplied crystal mode multiplies a crystal up to 10 MHz by four, up to 40 MHz.
// - Crystal path uses the multiplier only when the mode field equals 0110.
// - In multiplied crystal mode the software multiplier enable has no effect.
// - With internal source the multiplier is software switchable, giving up to 32 MHz.
// - Internal fast oscillator gives 8 MHz direct or postscaled 31 kHz to 4 MHz.
// - Internal fast oscillator runs only when 125 kHz to 8 MHz is selected.
// - Slow oscillator runs when chosen or when timer, monitor, watchdog or two-speed enabled.
// - Frequency select field in oscillator control register picks direct or postscaled source.
// - Internal clock-out mode: output pin gives clock over four, input pin is port bit 7.
// - Internal dual I/O mode: input pin is port bit 7, output pin port bit 6.
// - Internal multiplier usable only when mode field is 1001 or 1000.
// - Internal multiplier works only with frequency select 111 or 110, otherwise off.
package osm_pkg;
  // Register byte offsets
  localparam logic [3:0] OSM_CTRL_OFS = 4'h0;
  localparam logic [3:0] OSM_TUNE_OFS = 4'h4;
  localparam logic [3:0] OSM_FEAT_OFS = 4'h8;
  localparam logic [3:0] OSM_STAT_OFS = 4'hc;
  // Field positions
  localparam int OSM_FSEL_LSB = 4;
  localparam int OSM_PLL_SW_ENABLE_BIT = 6;
  localparam int OSM_LOSRC_BIT = 7;
  localparam int OSM_TUNE_W = 5;
  // Reset values
  localparam logic [2:0] OSM_FSEL_RST = 3'h0;
  localparam logic [7:0] OSM_TUNE_RST = 8'h00;
  localparam logic [3:0] OSM_FEAT_RST = 4'h0;
  // Frequency select codes for the multiplier and the slow source
  localparam logic [2:0] OSM_FSEL_8M = 3'h7;
  localparam logic [2:0] OSM_FSEL_4M = 3'h6;
  localparam logic [2:0] OSM_FSEL_SLOW = 3'h0;
  // Mode codes given, and assumed ones
  localparam logic [3:0] OSM_MODE_HIGH_SPEED_MULTIPLIED_MODE = 4'h6;
  localparam logic [3:0] OSM_MODE_INTDUAL = 4'h8;
  localparam logic [3:0] OSM_MODE_INTCLK = 4'h9;
  localparam logic [3:0] OSM_MODE_LP = 4'h0;
  localparam logic [3:0] OSM_MODE_XT = 4'h1;
  localparam logic [3:0] OSM_MODE_HS = 4'h2;
  localparam logic [3:0] OSM_MODE_RC = 4'h3;
  localparam logic [3:0] OSM_MODE_EC = 4'h4;
  localparam logic [3:0] OSM_MODE_EXT_CLOCK_PIN_IO_MODE = 4'h5;
  localparam logic [3:0] OSM_MODE_RESISTOR_CAP_IO_MODE = 4'h7;
  // Frequencies in kHz and multiplier factor
  localparam int OSM_PLL_MULT = 4;
  localparam int OSM_HS_PLL_IN_KHZ = 10000;
  localparam int OSM_HS_PLL_OUT_KHZ = OSM_HS_PLL_IN_KHZ * OSM_PLL_MULT;
  localparam int OSM_INT_PLL_OUT_KHZ = 32000;
  localparam int OSM_FAST_KHZ = 8000;
  localparam int OSM_SLOW_KHZ = 31;
  // Postscale shift for the 31 kHz tap of the fast oscillator
  localparam logic [3:0] OSM_SLOW_SHIFT = 4'h8;
  // Clock source seen by the core
  typedef enum logic [2:0] {
    OSM_SRC_XTAL, OSM_SRC_EXTCLK, OSM_SRC_RC, OSM_SRC_FAST, OSM_SRC_POST, OSM_SRC_SLOW
  } osm_src_t;
endpackage : osm_pkg

/* tb/osm_ext_osc.sv */
// Outside party on the two oscillator pins: clock source or port-pin load
`timescale 1ns/1ps
module osm_ext_osc (
  input wire logic runClk,
  input wire logic lvl6,
  input wire logic lvl7,
  input wire logic dutInOut,
  input wire logic dutInOe,
  input wire logic dutOutOut,
  input wire logic dutOutOe,
  output logic oscInPinIn,
  output logic oscOutPinIn
);
  logic extClk = 1'b0;
  // Free-running source, phase unrelated to clk
  always #7 extClk = ~extClk;
  // Wire levels resolved from both parties' enables
  assign oscInPinIn = dutInOe ? dutInOut : (runClk ? extClk : lvl7);
  assign oscOutPinIn = dutOutOe ? dutOutOut : lvl6;
endmodule : osm_ext_osc

/* tb/osm_mode_select_tb.sv */
// Self-checking bench for the oscillator mode select block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmpCount++; if ((gt) !== (ex)) begin nErrors++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module osm_mode_select_tb;
  import osm_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] modeCfg = 4'h0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, inOut, inOe, outOut, outOe, inIn, outIn, p6In, p7In;
  logic p6Out = 1'b0, p6Oe = 1'b0, p7Out = 1'b0, p7Oe = 1'b0;
  logic runClk = 1'b0, lvl6 = 1'b0, lvl7 = 1'b0;
  osm_src_t clkSource;
  logic [3:0] postShift;
  logic pllOn, fastOscRun, slowOscRun, startDelayReq, cfgLoaded;
  int nErrors = 0;
  int cmpCount = 0;
  int seed = 32'h03fc51c2;
  // 100 MHz clock
  always #5 clk = ~clk;
  osm_mode_select u_dut (.clk(clk), .reset(reset), .oscModeConfig(modeCfg), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .oscInPinIn(inIn),
    .oscInPinOut(inOut), .oscInPinOe(inOe), .oscOutPinIn(outIn), .oscOutPinOut(outOut), .oscOutPinOe(outOe),
    .portBit6Out(p6Out), .portBit6Oe(p6Oe), .portBit7Out(p7Out), .portBit7Oe(p7Oe), .portBit6In(p6In),
    .portBit7In(p7In), .clkSource(clkSource), .postShift(postShift), .pllOn(pllOn), .fastOscRun(fastOscRun),
    .slowOscRun(slowOscRun), .startDelayReq(startDelayReq), .cfgLoaded(cfgLoaded));
  osm_ext_osc u_ext (.runClk(runClk), .lvl6(lvl6), .lvl7(lvl7), .dutInOut(inOut), .dutInOe(inOe),
    .dutOutOut(outOut), .dutOutOe(outOe), .oscInPinIn(inIn), .oscOutPinIn(outIn));
  // Single place where the run ends
  task automatic giveVerdict();
    if (nErrors == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : giveVerdict
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // One bus transfer; request held until waitrequest is seen low
  task automatic busOp(input logic we, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk);
    {address, writedata, write, read} <= {a, wd, we, ~we};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    {write, read} <= 2'b00;
    if (i == 20) begin
      nErrors++;
      giveVerdict();
    end
  endtask : busOp
  // Expected status low byte; slow assumes the low-source bit is kept 0
  function automatic logic [7:0] expStat(input logic [3:0] m, input logic [2:0] f, input logic pe,
                                         input logic [3:0] ft);
    logic im;
    logic xt;
    im = (m == OSM_MODE_INTDUAL) || (m == OSM_MODE_INTCLK);
    xt = (m == OSM_MODE_LP) || (m == OSM_MODE_XT) || (m == OSM_MODE_HS) || (m == OSM_MODE_HIGH_SPEED_MULTIPLIED_MODE);
    return {xt, (ft != 4'h0) || (im && f == 3'h0), im && f != 3'h0,
            (m == OSM_MODE_HIGH_SPEED_MULTIPLIED_MODE) || (im && pe && f[2:1] == 2'b11), m};
  endfunction : expStat
  // Expected core clock source; low-source bit kept 0
  function automatic osm_src_t expSrc(input logic [3:0] m, input logic [2:0] f);
    if (m == OSM_MODE_LP || m == OSM_MODE_XT || m == OSM_MODE_HS || m == OSM_MODE_HIGH_SPEED_MULTIPLIED_MODE) return OSM_SRC_XTAL;
    if (m == OSM_MODE_EC || m == OSM_MODE_EXT_CLOCK_PIN_IO_MODE) return OSM_SRC_EXTCLK;
    if (m == OSM_MODE_RC || m == OSM_MODE_RESISTOR_CAP_IO_MODE) return OSM_SRC_RC;
    if (f == 3'h7) return OSM_SRC_FAST;
    if (f == 3'h0) return OSM_SRC_SLOW;
    return OSM_SRC_POST;
  endfunction : expSrc
  // Output pin must carry a divide-by-four square wave
  task automatic clkOutCheck();
    logic [9:0] s;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      s[i] = outOut;
    end
    `CHK("clkout enable", 1'b1, outOe)
    for (int i = 0; i < 8; i++) `CHK("clkout phase", ~s[i], s[i+2])
  endtask : clkOutCheck
  // Port-bit routing on both pins: drive out, then sense a released pin
  task automatic ioCheck(input logic e6, input logic e7);
    logic v6;
    logic v7;
    v6 = 1'($random(seed));
    v7 = 1'($random(seed));
    @(posedge clk);
    {p6Out, p6Oe, p7Out, p7Oe} <= {v6, 1'b1, v7, 1'b1};
    cyc(3);
    if (e6) `CHK("out pin drive", {1'b1, v6}, {outOe, outOut})
    if (e7) `CHK("in pin drive", {1'b1, v7}, {inOe, inOut})
    {p6Oe, p7Oe, lvl6, lvl7} <= {2'b00, ~v6, ~v7};
    cyc(5);
    `CHK("bit6 sense", e6 & ~v6, p6In)
    `CHK("bit7 sense", e7 & ~v7, p7In)
  endtask : ioCheck
  // Every mode code, each after its own reset; registers then pins
  initial begin
    logic [31:0] rd, wd;
    logic [7:0] es;
    logic [3:0] ft;
    logic [2:0] f;
    logic im, pe;
    cyc(2);
    for (int m = 0; m < 16; m++) begin
      im = (m == OSM_MODE_INTDUAL) || (m == OSM_MODE_INTCLK);
      @(posedge clk);
      {reset, modeCfg, runClk} <= {1'b1, 4'(m), ~im && m < 10};
      cyc(4);
      reset <= 1'b0;
      for (int i = 0; i < 10 && cfgLoaded !== 1'b1; i++) @(posedge clk);
      `CHK("cfg loaded", 1'b1, cfgLoaded)
      busOp(1'b0, OSM_CTRL_OFS, 32'h0, rd);
      `CHK("ctrl reset", {25'h0, OSM_FSEL_RST, 4'h0}, rd)
      busOp(1'b0, OSM_TUNE_OFS, 32'h0, rd);
      `CHK("tune reset", {24'h0, OSM_TUNE_RST}, rd)
      for (int it = 0; it < 4; it++) begin
        wd = $random(seed);
        f = (it == 0) ? 3'h7 : (it == 1) ? 3'h0 : (it == 2) ? 3'h6 : wd[6:4];
        wd[6:4] = f;
        busOp(1'b1, OSM_CTRL_OFS, wd, rd);
        busOp(1'b0, OSM_CTRL_OFS, 32'h0, rd);
        `CHK("ctrl", wd & 32'h70, rd)
        wd = $random(seed);
        wd[7] = 1'b0;
        wd[6] = wd[6] | (it < 3);
        pe = wd[6];
        busOp(1'b1, OSM_TUNE_OFS, wd, rd);
        busOp(1'b0, OSM_TUNE_OFS, 32'h0, rd);
        `CHK("tune", (wd & 32'h1f) | {25'h0, im & pe, 6'h0}, rd)
        wd = $random(seed);
        if (it < 2) wd[3:0] = 4'h0;
        ft = wd[3:0];
        busOp(1'b1, OSM_FEAT_OFS, wd, rd);
        busOp(1'b1, 4'h2, $random(seed), rd);
        busOp(1'b0, 4'h2, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        busOp(1'b1, OSM_STAT_OFS, $random(seed), rd);
        cyc(2);
        es = expStat(4'(m), f, pe, ft);
        busOp(1'b0, OSM_STAT_OFS, 32'h0, rd);
        `CHK("status", es, rd[7:0])
        `CHK("flags", es[7:4], {startDelayReq, slowOscRun, fastOscRun, pllOn})
        if (im && f != 3'h0) `CHK("post shift", {1'b0, 3'h7 - f}, postShift)
        if (m < 10) `CHK("source", expSrc(4'(m), f), clkSource)
      end
      if (m == OSM_MODE_EC || m == OSM_MODE_RC || m == OSM_MODE_INTCLK) clkOutCheck();
      ioCheck(m == OSM_MODE_EXT_CLOCK_PIN_IO_MODE || m == OSM_MODE_RESISTOR_CAP_IO_MODE || m == OSM_MODE_INTDUAL, im);
    end
    giveVerdict();
  end
endmodule : osm_mode_select_tb

/* verilog/osm_mode_select.sv */
// Oscillator mode select: mode decode, source selection, pin reassignment, register slave
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module osm_mode_select #(
  parameter logic [3:0] MODE_LP = osm_pkg::OSM_MODE_LP,
  parameter logic [3:0] MODE_XT = osm_pkg::OSM_MODE_XT,
  parameter logic [3:0] MODE_HS = osm_pkg::OSM_MODE_HS,
  parameter logic [3:0] MODE_RC = osm_pkg::OSM_MODE_RC,
  parameter logic [3:0] MODE_EC = osm_pkg::OSM_MODE_EC,
  parameter logic [3:0] MODE_EXT_CLOCK_PIN_IO_MODE = osm_pkg::OSM_MODE_EXT_CLOCK_PIN_IO_MODE,
  parameter logic [3:0] MODE_RESISTOR_CAP_IO_MODE = osm_pkg::OSM_MODE_RESISTOR_CAP_IO_MODE
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] oscModeConfig,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic oscInPinIn,
  output logic oscInPinOut,
  output logic oscInPinOe,
  input wire logic oscOutPinIn,
  output logic oscOutPinOut,
  output logic oscOutPinOe,
  input wire logic portBit6Out,
  input wire logic portBit6Oe,
  input wire logic portBit7Out,
  input wire logic portBit7Oe,
  output logic portBit6In,
  output logic portBit7In,
  output osm_pkg::osm_src_t clkSource,
  output logic [3:0] postShift,
  output logic pllOn,
  output logic fastOscRun,
  output logic slowOscRun,
  output logic startDelayReq,
  output logic cfgLoaded
);
  import osm_pkg::*;

  logic [3:0] modeSync1_q, modeSync2_q, mode_q;
  logic cfgLoaded_q;
  logic [2:0] fsel_q;
  logic loSrc_q, pllSw_q;
  logic [OSM_TUNE_W-1:0] tune_q;
  logic [3:0] feat_q;
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic [1:0] div_q;
  logic in1_q, in2_q, out1_q, out2_q;
  logic inOut_q, inOe_q, outOut_q, outOe_q, bit6In_q, bit7In_q;
  osm_src_t src_q;
  logic [3:0] shift_q;
  logic pll_q, fast_q, slow_q, sdly_q;

  // Postscale shift from frequency select: 111 is direct, each step down to 001 halves
  function automatic logic [3:0] fsel_shift(input logic [2:0] f, input logic lo);
    if (f == OSM_FSEL_SLOW) begin
      fsel_shift = lo ? OSM_SLOW_SHIFT : 4'h0;
    end else begin
      fsel_shift = 4'(3'h7 - f);
    end
  endfunction : fsel_shift

  // Mode classes
  wire isCrystal = (mode_q == MODE_LP) || (mode_q == MODE_XT) || (mode_q == MODE_HS) ||
    (mode_q == OSM_MODE_HIGH_SPEED_MULTIPLIED_MODE);
  wire isHsPll = (mode_q == OSM_MODE_HIGH_SPEED_MULTIPLIED_MODE);
  wire isExtClk = (mode_q == MODE_EC) || (mode_q == MODE_EXT_CLOCK_PIN_IO_MODE);
  wire isRc = (mode_q == MODE_RC) || (mode_q == MODE_RESISTOR_CAP_IO_MODE);
  wire isInt = (mode_q == OSM_MODE_INTCLK) || (mode_q == OSM_MODE_INTDUAL);
  wire clkOutMode = (mode_q == MODE_EC) || (mode_q == MODE_RC) || (mode_q == OSM_MODE_INTCLK);
  wire bit6Mode = (mode_q == MODE_EXT_CLOCK_PIN_IO_MODE) || (mode_q == MODE_RESISTOR_CAP_IO_MODE) || (mode_q == OSM_MODE_INTDUAL);
  wire bit7Mode = isInt;
  wire fselHigh = (fsel_q == OSM_FSEL_8M) || (fsel_q == OSM_FSEL_4M);
  wire pllSwAvail = isInt;
  wire featAny = |feat_q;
  wire slowChosen = isInt && (fsel_q == OSM_FSEL_SLOW) && !loSrc_q;

  // Next values for the clock control outputs
  wire pll_d = cfgLoaded_q && (isHsPll || (isInt && pllSw_q && fselHigh));
  wire fast_d = cfgLoaded_q && isInt && (fsel_q != OSM_FSEL_SLOW);
  wire slow_d = featAny || (cfgLoaded_q && slowChosen);
  wire sdly_d = cfgLoaded_q && isCrystal;
  wire [3:0] shift_d = isInt ? fsel_shift(fsel_q, loSrc_q) : 4'h0;
  osm_src_t src_d;
  always_comb begin
    // Core clock source, internal modes steered by frequency select
    if (isCrystal) begin
      src_d = OSM_SRC_XTAL;
    end else if (isExtClk) begin
      src_d = OSM_SRC_EXTCLK;
    end else if (isRc) begin
      src_d = OSM_SRC_RC;
    end else if (fsel_q == OSM_FSEL_8M) begin
      src_d = OSM_SRC_FAST;
    end else if (slowChosen) begin
      src_d = OSM_SRC_SLOW;
    end else begin
      src_d = OSM_SRC_POST;
    end
  end

  // Pin outputs: crystal modes leave both pins to the analogue oscillator
  wire outOut_d = clkOutMode ? div_q[1] : portBit6Out;
  wire outOe_d = cfgLoaded_q && (clkOutMode || (bit6Mode && portBit6Oe));
  wire inOut_d = portBit7Out;
  wire inOe_d = cfgLoaded_q && bit7Mode && portBit7Oe;

  // Register bus decode
  wire req = read || write;
  wire hitCtrl = (address == OSM_CTRL_OFS);
  wire hitTune = (address == OSM_TUNE_OFS);
  wire hitFeat = (address == OSM_FEAT_OFS);
  wire hitStat = (address == OSM_STAT_OFS);
  wire wrNow = write && !waitreq_q;
  wire [31:0] rdMux = hitCtrl ? {24'h0, 1'b0, fsel_q, 4'h0} :
    hitTune ? {24'h0, loSrc_q, pllSw_q, 1'b0, tune_q} :
    hitFeat ? {28'h0, feat_q} :
    hitStat ? {19'h0, 1'(src_q), shift_q, sdly_q, slow_q, fast_q, pll_q, mode_q} : 32'h0;

  // Configuration capture, pin field synchronised before use
  always_ff @(posedge clk) begin
    modeSync1_q <= oscModeConfig;
    modeSync2_q <= modeSync1_q;
    if (reset) begin
      mode_q <= 4'h0;
      cfgLoaded_q <= 1'b0;
    end else if (!cfgLoaded_q) begin
      mode_q <= modeSync2_q;
      cfgLoaded_q <= 1'b1;
    end
  end

  // One wait cycle per access keeps read data stable at the taking edge
  always_ff @(posedge clk) begin
    if (reset) begin
      waitreq_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      waitreq_q <= !(req && waitreq_q);
      rdata_q <= rdMux;
    end
  end

  // Software registers; multiplier enable reads zero where unavailable
  always_ff @(posedge clk) begin
    if (reset) begin
      fsel_q <= OSM_FSEL_RST;
      {loSrc_q, pllSw_q, tune_q} <= {OSM_TUNE_RST[7:6], OSM_TUNE_RST[OSM_TUNE_W-1:0]};
      feat_q <= OSM_FEAT_RST;
    end else begin
      if (wrNow && hitCtrl) fsel_q <= writedata[OSM_FSEL_LSB +: 3];
      if (wrNow && hitTune) begin
        loSrc_q <= writedata[OSM_LOSRC_BIT];
        tune_q <= writedata[OSM_TUNE_W-1:0];
      end
      if (!pllSwAvail) begin
        pllSw_q <= 1'b0;
      end else if (wrNow && hitTune) begin
        pllSw_q <= writedata[OSM_PLL_SW_ENABLE_BIT];
      end
      if (wrNow && hitFeat) feat_q <= writedata[3:0];
    end
  end

  // Clock over four divider; clk stands for the device clock
  always_ff @(posedge clk) begin
    if (reset) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end

  // Pin input synchronisers
  always_ff @(posedge clk) begin
    in1_q <= oscInPinIn;
    in2_q <= in1_q;
    out1_q <= oscOutPinIn;
    out2_q <= out1_q;
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      {inOut_q, inOe_q, outOut_q, outOe_q, bit6In_q, bit7In_q} <= 6'h0;
      src_q <= OSM_SRC_XTAL;
      shift_q <= 4'h0;
      {pll_q, fast_q, slow_q, sdly_q} <= 4'h0;
    end else begin
      inOut_q <= inOut_d;
      inOe_q <= inOe_d;
      outOut_q <= outOut_d;
      outOe_q <= outOe_d;
      bit6In_q <= bit6Mode && out2_q;
      bit7In_q <= bit7Mode && in2_q;
      src_q <= src_d;
      shift_q <= shift_d;
      pll_q <= pll_d;
      fast_q <= fast_d;
      slow_q <= slow_d;
      sdly_q <= sdly_d;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = waitreq_q;
  assign oscInPinOut = inOut_q;
  assign oscInPinOe = inOe_q;
  assign oscOutPinOut = outOut_q;
  assign oscOutPinOe = outOe_q;
  assign portBit6In = bit6In_q;
  assign portBit7In = bit7In_q;
  assign clkSource = src_q;
  assign postShift = shift_q;
  assign pllOn = pll_q;
  assign fastOscRun = fast_q;
  assign slowOscRun = slow_q;
  assign startDelayReq = sdly_q;
  assign cfgLoaded = cfgLoaded_q;

  // Checks on the block's own outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  mode_frozen_a: assert property (cfgLoaded_q |=> $stable(mode_q))
    else $error("mode changed after capture");
  xtal_pins_a: assert property (cfgLoaded_q && isCrystal |=> !oscOutPinOe && !oscInPinOe)
    else $error("crystal pin driven");
  ext_nodelay_a: assert property (cfgLoaded_q && isExtClk |=> !startDelayReq)
    else $error("start-up delay in external clock mode");
  // Four cycles in the mode so both compared samples come from the divider, not the port value
  clkout_quarter_a: assert property (clkOutMode [*4] |-> oscOutPinOut != $past(oscOutPinOut, 2))
    else $error("clock out not at quarter rate");
  bit6_follow_a: assert property (cfgLoaded_q && bit6Mode |=> oscOutPinOe == $past(portBit6Oe))
    else $error("bit 6 enable not followed");
  high_speed_multiplied_mode_on_a: assert property (cfgLoaded_q && isHsPll |=> pllOn)
    else $error("multiplier off in multiplied crystal mode");
  pll_gate_a: assert property (!isHsPll && !(isInt && fselHigh) |=> !pllOn)
    else $error("multiplier on outside allowed settings");
  fast_off_a: assert property (fsel_q == OSM_FSEL_SLOW |=> !fastOscRun)
    else $error("fast oscillator on at 31 kHz");
  slow_feat_a: assert property (featAny |=> slowOscRun)
    else $error("slow oscillator off with feature enabled");
  bus_answer_a: assert property (req && waitrequest |-> ##1 !waitrequest)
    else $error("bus answer late");

  xtal_mode_c: cover property (cfgLoaded_q && isHsPll ##1 pllOn);
  int_pll_c: cover property (isInt && pllSw_q && fselHigh ##1 pllOn);
  clkout_c: cover property ((cfgLoaded_q && clkOutMode) [*4]);
  dual_io_c: cover property (cfgLoaded_q && mode_q == OSM_MODE_INTDUAL && portBit7Oe ##1 oscInPinOe);
endmodule : osm_mode_select
